// >>> core/fpklc_pkg.sv
// Constants, carrier types and contract list of the front-panel key block
// Contract
// R1 - The power lamp is lit for as long as the device is powered and ready.
// R2 - The run-command lamp is lit while a run command exists or the output stage delivers power.
// R3 - The alarm lamp is lit while the inverter is held in the trip state.
// R4 - The key-valid lamp is lit when the panel key can act and is off while a run command is active.
// R5 - After a key-started run ends, the key-valid lamp stays lit through the deceleration.
// R6 - A key press during a terminal run holds the key-valid lamp off until the motor has stopped. The code also waits for the run terminals to drop.
// R7 - The panel key is enabled after reset and is ignored when its enable parameter is cleared.
// R8 - A key press in the trip state clears the trip and returns to normal operation.
// R9 - A key press starts the motor whatever run-command source is selected.
// R10 - With serial protocol selected, holding the key 5 s from power-up and releasing it selects external-operator mode.
// R11 - The port runs the serial protocol only when both the changeover switch and the parameter select it.
// R12 - While the parameter selects the serial protocol, an attached external operator is refused.
// R13 - The device becomes ready, lamps on, about 1.5 s after power-up.
// R14 - At ready the display shows the item chosen by the initial-display parameter, output frequency by default.
// R15 - Data changed through the programming tool is committed to storage only at power-down.
// R16 - A stop from the key makes the motor decelerate rather than cut the output.
// R17 - The key is debounced, acts once per press, and means run, stop or reset by state.
package fpklc_pkg;

  // Clock rate and timings
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
  localparam int unsigned READY_TIME_MS = 1500;
  localparam int unsigned READY_CYC     = READY_TIME_MS * CYC_PER_MS;
  localparam int unsigned HOLD_TIME_MS  = 5000;
  localparam int unsigned HOLD_CYC      = HOLD_TIME_MS * CYC_PER_MS;
  localparam int unsigned DEB_TIME_MS   = 20;
  localparam int unsigned DEB_CYC       = DEB_TIME_MS * CYC_PER_MS;
  localparam int unsigned CNT_W         = 27;

  // Register byte offsets
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;

  // Control register field positions
  localparam int unsigned CTRL_KEY_EN_BIT = 0;
  localparam int unsigned CTRL_SRC_LSB    = 1;
  localparam int unsigned CTRL_COMM_BIT   = 3;
  localparam int unsigned CTRL_DISP_LSB   = 4;

  // Run-command source codes
  localparam logic [1:0] SRC_PANEL    = 2'h0;
  localparam logic [1:0] SRC_TERMINAL = 2'h1;

  // Initial display code for output frequency monitor
  localparam logic [3:0] DISP_OUT_FREQ = 4'h0;

  // Parameter set written by software
  typedef struct packed {
    logic [3:0] initial_display_param;
    logic       comm_select_param;
    logic [1:0] run_source_select;
    logic       panel_key_enable_param;
  } fpklc_ctrl_t;

  localparam fpklc_ctrl_t CTRL_RESET = '{
    initial_display_param:  DISP_OUT_FREQ,
    comm_select_param:      1'b0,
    run_source_select:      SRC_PANEL,
    panel_key_enable_param: 1'b1
  };

  // Panel lamps
  typedef struct packed {
    logic key_valid_lamp;
    logic alarm_lamp;
    logic run_cmd_lamp;
    logic power_lamp;
  } fpklc_lamps_t;

  // Key sequencer states, Gray along boot, stop, run, trip
  typedef enum logic [1:0] {
    ST_BOOT = 2'b00,
    ST_STOP = 2'b01,
    ST_RUN  = 2'b11,
    ST_TRIP = 2'b10
  } fpklc_state_t;

endpackage

// >>> core/fpklc_debounce.sv
// Key debouncer: stable level and one pulse per press
`timescale 1ns/1ps
module fpklc_debounce
  import fpklc_pkg::*;
#(
  parameter int unsigned DEB_CYCLES = DEB_CYC
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic reset_n,
  // Key
  input  wire logic key_raw,
  output logic      key_level,
  output logic      key_press
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             level;
    logic             press;
  } fpklc_deb_t;

  fpklc_deb_t s_reg;
  fpklc_deb_t s_next;

  // Level changes only after the raw key held steady for the whole window
  always_comb begin
    s_next = s_reg;
    s_next.press = 1'b0;
    if (key_raw == s_reg.level) begin
      s_next.cnt = '0;
    end else if (s_reg.cnt == CNT_W'(DEB_CYCLES - 1)) begin
      s_next.cnt   = '0;
      s_next.level = key_raw;
      s_next.press = key_raw;
    end else begin
      s_next.cnt = s_reg.cnt + CNT_W'(1);
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign key_level = s_reg.level;
  assign key_press = s_reg.press;

endmodule

// >>> core/fpklc_top.sv
// Front-panel key and lamp controller with Avalon-MM register slave
//
// Chosen here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
module fpklc_top
  import fpklc_pkg::*;
#(
  parameter int unsigned READY_CYCLES = READY_CYC,
  parameter int unsigned HOLD_CYCLES  = HOLD_CYC,
  parameter int unsigned DEB_CYCLES   = DEB_CYC
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Panel key and run terminals
  input  wire logic        panel_key_raw,
  input  wire logic        forward_run_terminal,
  input  wire logic        reverse_run_terminal,
  // Inverter status
  input  wire logic        trip_event,
  input  wire logic        output_active,
  input  wire logic        power_down,
  input  wire logic        pc_param_written,
  // Serial port
  input  wire logic        changeover_serial,
  input  wire logic        ext_operator_attached,
  output logic             serial_proto_en,
  output logic             ext_operator_en,
  output logic             ext_operator_refused,
  // Lamps and commands
  output fpklc_lamps_t     lamps,
  output logic             run_command,
  output logic             decel_stop,
  output logic             trip_reset,
  output logic             nv_commit,
  output logic      [3:0]  display_select
);

  typedef struct packed {
    fpklc_state_t     st;
    logic [CNT_W-1:0] boot_cnt;
    logic [CNT_W-1:0] hold_cnt;
    logic             hold_on;
    logic             ext_op;
    logic             lockout;
    logic             decel;
    logic             dirty;
    logic             pd_q;
    logic             trip_rst;
    logic             commit;
    fpklc_ctrl_t      ctrl;
    fpklc_lamps_t     lamps;
    logic             run_cmd;
    logic             serial_en;
    logic             ext_en;
    logic             refused;
    logic [3:0]       disp;
    logic             wait_rq;
    logic [31:0]      rdata;
  } fpklc_top_t;

  fpklc_top_t s_reg;
  fpklc_top_t s_next;

  logic key_level;
  logic key_press;
  logic term_req;
  logic term_run;
  logic key_act;

  // Saturating step of a timing counter
  function automatic logic [CNT_W-1:0] cnt_step(
    input logic [CNT_W-1:0] c,
    input int unsigned      lim
  );
    if (c == CNT_W'(lim - 1)) begin
      cnt_step = c;
    end else begin
      cnt_step = c + CNT_W'(1);
    end
  endfunction

  // Status word seen by software
  function automatic logic [31:0] status_word(input fpklc_top_t s);
    status_word = {19'h00000, s.refused, s.dirty, s.lockout, s.serial_en,
                   s.ext_op, s.decel, s.run_cmd, s.st, s.lamps};
  endfunction

  // R17 key debounce
  fpklc_debounce #(
    .DEB_CYCLES (DEB_CYCLES)
  ) u_deb (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .key_raw   (panel_key_raw),
    .key_level (key_level),
    .key_press (key_press)
  );

  // Terminal run request counts only with the terminal source selected
  assign term_req = (forward_run_terminal | reverse_run_terminal) &
                    (s_reg.ctrl.run_source_select == SRC_TERMINAL);
  assign term_run = term_req & ~s_reg.lockout & (s_reg.st == ST_STOP);

  // R7 key gate; presses during boot or the power-up hold are not commands
  assign key_act = key_press & s_reg.ctrl.panel_key_enable_param &
                   ~s_reg.hold_on & (s_reg.st != ST_BOOT);

  // Next-state logic for the whole block
  always_comb begin
    s_next = s_reg;
    s_next.trip_rst = 1'b0;
    s_next.commit   = 1'b0;
    s_next.pd_q     = power_down;

    // R13 start-up delay before ready
    if (s_reg.st == ST_BOOT) begin
      s_next.boot_cnt = cnt_step(s_reg.boot_cnt, READY_CYCLES);
      if (s_reg.boot_cnt == CNT_W'(READY_CYCLES - 1)) begin
        s_next.st = ST_STOP;
        // R14 initial display taken at ready
        s_next.disp = s_reg.ctrl.initial_display_param;
      end
    end

    // R10 power-up long press selects external-operator mode
    if (s_reg.hold_on) begin
      // Debounced level lags the raw key after reset; a key held from
      // power-up must not be read as already released
      if (key_level) begin
        s_next.hold_cnt = cnt_step(s_reg.hold_cnt, HOLD_CYCLES);
      end else if (s_reg.hold_cnt != '0 || !panel_key_raw) begin
        s_next.hold_on = 1'b0;
        if (s_reg.hold_cnt == CNT_W'(HOLD_CYCLES - 1) &&
            s_reg.ctrl.comm_select_param) begin
          s_next.ext_op = 1'b1;
        end
      end
    end

    // R16 deceleration request ends once the output stage is idle
    if (!output_active) begin
      s_next.decel = 1'b0;
    end
    // R6 lockout lasts until the motor stops and terminals drop
    if (!output_active && !term_req) begin
      s_next.lockout = 1'b0;
    end

    // R17 one action per press, chosen by state
    if (key_act) begin
      case (s_reg.st)
        ST_TRIP: begin
          // R8 trip reset from key
          s_next.st       = ST_STOP;
          s_next.trip_rst = 1'b1;
        end
        ST_RUN: begin
          // R16 key stop decelerates
          s_next.st    = ST_STOP;
          s_next.decel = 1'b1;
        end
        default: begin
          if (term_run) begin
            // R6 key during terminal run stops it and locks out
            s_next.lockout = 1'b1;
            s_next.decel   = 1'b1;
          end else begin
            // R9 key starts regardless of source
            s_next.st = ST_RUN;
          end
        end
      endcase
    end

    // R3 trip event wins over a reset press in the same cycle
    if (trip_event && s_reg.st != ST_BOOT) begin
      s_next.st    = ST_TRIP;
      s_next.decel = 1'b0;
    end

    // R15 commit edited data only on the power-down edge
    if (power_down && !s_reg.pd_q && s_reg.dirty) begin
      s_next.commit = 1'b1;
      s_next.dirty  = 1'b0;
    end
    if (pc_param_written) begin
      s_next.dirty = 1'b1;
    end

    // Run command from key state or permitted terminal request
    s_next.run_cmd = (s_next.st == ST_RUN) |
                     (term_req & ~s_next.lockout & (s_next.st == ST_STOP));

    // R1 power lamp once ready
    s_next.lamps.power_lamp = (s_next.st != ST_BOOT);
    // R2 run-command lamp covers command and output power
    s_next.lamps.run_cmd_lamp = (s_next.st != ST_BOOT) &
                                (s_next.run_cmd | output_active);
    // R3 alarm lamp in trip
    s_next.lamps.alarm_lamp = (s_next.st == ST_TRIP);
    // R4 R5 key-valid lamp, lit through key-stop deceleration
    s_next.lamps.key_valid_lamp = (s_next.st != ST_BOOT) &
                                  s_next.ctrl.panel_key_enable_param &
                                  ~s_next.run_cmd & ~s_next.lockout;

    // R11 serial protocol needs both switch and parameter
    s_next.serial_en = changeover_serial & s_next.ctrl.comm_select_param &
                       ~s_next.ext_op;
    // R12 external operator refused under serial parameter
    s_next.ext_en  = ~s_next.ctrl.comm_select_param | s_next.ext_op;
    s_next.refused = ext_operator_attached & ~s_next.ext_en;

    // Avalon slave: one wait cycle, then answer with waitrequest low
    s_next.wait_rq = ~((avs_read | avs_write) & s_reg.wait_rq);
    if (avs_read && s_reg.wait_rq) begin
      if (avs_address == OFS_CTRL) begin
        s_next.rdata = {24'h000000, s_reg.ctrl};
      end else if (avs_address == OFS_STATUS) begin
        s_next.rdata = status_word(s_reg);
      end else begin
        s_next.rdata = 32'h00000000;
      end
    end
    // Write takes effect at the edge where waitrequest is seen low
    if (avs_write && !s_reg.wait_rq && avs_byteenable[0]) begin
      if (avs_address == OFS_CTRL) begin
        s_next.ctrl = fpklc_ctrl_t'(avs_writedata[7:0]);
      end
    end
  end

  // State register; reset keeps the key enabled and display at frequency
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_reg         <= '0;
      s_reg.st      <= ST_BOOT;
      s_reg.hold_on <= 1'b1;
      s_reg.ctrl    <= CTRL_RESET;
      s_reg.disp    <= DISP_OUT_FREQ;
      s_reg.ext_en  <= 1'b1;
      s_reg.wait_rq <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  assign avs_readdata         = s_reg.rdata;
  assign avs_waitrequest      = s_reg.wait_rq;
  assign lamps                = s_reg.lamps;
  assign run_command          = s_reg.run_cmd;
  assign decel_stop           = s_reg.decel;
  assign trip_reset           = s_reg.trip_rst;
  assign nv_commit            = s_reg.commit;
  assign display_select       = s_reg.disp;
  assign serial_proto_en      = s_reg.serial_en;
  assign ext_operator_en      = s_reg.ext_en;
  assign ext_operator_refused = s_reg.refused;

endmodule

// >>> testbench/fpklc_properties.sv
// Port-level checks of the front-panel key and lamp block
`timescale 1ns/1ps
module fpklc_properties
  import fpklc_pkg::*;
#(
  parameter int unsigned READY_CYCLES = READY_CYC
) (
  // Clock and reset
  input wire logic         core_clk,
  input wire logic         reset_n,
  // Inverter and port inputs
  input wire logic         trip_event,
  input wire logic         output_active,
  input wire logic         power_down,
  input wire logic         changeover_serial,
  input wire logic         ext_operator_attached,
  // Block outputs
  input wire fpklc_lamps_t lamps,
  input wire logic         run_command,
  input wire logic         decel_stop,
  input wire logic         trip_reset,
  input wire logic         nv_commit,
  input wire logic         serial_proto_en,
  input wire logic         ext_operator_refused
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  logic [31:0] up_cnt_reg;

  // Cycles since release; saturates so a long run cannot wrap it
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n)
      up_cnt_reg <= 32'h0;
    else if (up_cnt_reg != 32'hFFFFFFFF)
      up_cnt_reg <= up_cnt_reg + 32'h1;
  end

  boot_dark_a: assert property (
    !lamps.power_lamp |-> !(|lamps)) else $error("lamp lit before ready");
  ready_time_a: assert property (
    $rose(lamps.power_lamp) |-> (up_cnt_reg + 32'h1 >= READY_CYCLES)
      && (up_cnt_reg <= READY_CYCLES + 3)) else $error("ready time off");
  run_lamp_a: assert property (
    lamps.power_lamp && $past(run_command || output_active)
      && (run_command || output_active) |-> lamps.run_cmd_lamp)
    else $error("run lamp dark while driving");
  key_lamp_off_a: assert property (
    run_command && $past(run_command) |-> !lamps.key_valid_lamp)
    else $error("key lamp lit during run");
  alarm_rise_a: assert property (
    $rose(trip_event) && lamps.power_lamp |-> ##[1:3] lamps.alarm_lamp)
    else $error("alarm lamp missing after trip");
  trip_clear_a: assert property (
    trip_reset && !trip_event |-> ##[0:2] !lamps.alarm_lamp)
    else $error("alarm lamp kept after reset");
  decel_stop_a: assert property (
    $fell(run_command) && output_active |-> ##[0:1]
      (decel_stop || lamps.alarm_lamp)) else $error("stop without ramp");
  serial_gate_a: assert property (
    serial_proto_en |-> $past(changeover_serial))
    else $error("serial enabled with switch off");
  refused_a: assert property (
    ext_operator_refused |-> $past(ext_operator_attached))
    else $error("refusal without operator");
  commit_cause_a: assert property (
    nv_commit |-> $past(power_down) || $past(power_down, 2))
    else $error("commit without power down");
endmodule

bind fpklc_top fpklc_properties #(.READY_CYCLES(READY_CYCLES)) chk_u (.*);

// >>> testbench/fpklc_partner.sv
// Behavioural panel key, run terminals and motor
`timescale 1ns/1ps
module fpklc_partner #(
  parameter int unsigned DECEL_CYCLES = 30
) (
  // Clock and command
  input  wire logic core_clk,
  input  wire logic run_command,
  // Key, terminals and motor state
  output logic      panel_key_raw,
  output logic      forward_run_terminal,
  output logic      reverse_run_terminal,
  output logic      output_active
);
  int unsigned spin = 0;

  initial begin
    panel_key_raw = 1'b0;
    forward_run_terminal = 1'b0;
    reverse_run_terminal = 1'b0;
  end

  // Motor turns while driven, then ramps down; never stops at once
  always @(posedge core_clk) begin
    if (run_command || forward_run_terminal || reverse_run_terminal)
      spin <= DECEL_CYCLES;
    else if (spin != 0)
      spin <= spin - 1;
  end
  assign output_active = (spin != 0);

  // Key level, changed just after an edge
  task automatic key(input logic v);
    @(posedge core_clk);
    panel_key_raw <= v;
  endtask

  // Terminal run levels
  task automatic term(input logic fw, input logic rv);
    @(posedge core_clk);
    forward_run_terminal <= fw;
    reverse_run_terminal <= rv;
  endtask
endmodule

// >>> testbench/tb.sv
// Self-checking bench for the front-panel key and lamp block
`timescale 1ns/1ps
module tb;
  import fpklc_pkg::*;
  localparam int unsigned RDY = 20;
  localparam int unsigned HLD = 60;
  localparam int unsigned DEB = 3;
  logic         core_clk = 1'b0;
  logic         reset_n = 1'b0;
  logic [3:0]   avs_address = 4'h0;
  logic         avs_read = 1'b0;
  logic         avs_write = 1'b0;
  logic [31:0]  avs_writedata = 32'h0;
  logic [3:0]   avs_byteenable = 4'hF;
  logic [31:0]  avs_readdata;
  logic         avs_waitrequest;
  logic         panel_key_raw;
  logic         forward_run_terminal;
  logic         reverse_run_terminal;
  logic         output_active;
  logic         trip_event = 1'b0;
  logic         power_down = 1'b0;
  logic         pc_param_written = 1'b0;
  logic         changeover_serial = 1'b0;
  logic         ext_operator_attached = 1'b0;
  logic         serial_proto_en;
  logic         ext_operator_en;
  logic         ext_operator_refused;
  fpklc_lamps_t lamps;
  logic         run_command;
  logic         decel_stop;
  logic         trip_reset;
  logic         nv_commit;
  logic [3:0]   display_select;
  logic [31:0]  rd;
  logic [3:0]   disp;
  int           fails = 0;
  int           tests_run = 0;
  int           resets_seen = 0;
  int           commits = 0;
  int           cycles = 0;

  fpklc_top #(.READY_CYCLES(RDY), .HOLD_CYCLES(HLD), .DEB_CYCLES(DEB))
    dut_u (.*);
  fpklc_partner partner_u (.*);

  always #20 core_clk = ~core_clk;

  // Pulse tallies and hang guard; the ceiling is far above the sequence
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (trip_reset === 1'b1)
      resets_seen <= resets_seen + 1;
    if (nv_commit === 1'b1)
      commits <= commits + 1;
    if (cycles == 20000) begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (fails == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Outputs are read mid-cycle, well clear of the edge updates
  task automatic settle();
    @(negedge core_clk);
  endtask

  // One bus cycle, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do
      @(posedge core_clk);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // Press long enough to pass the debounce, then release and wait
  task automatic press();
    partner_u.key(1'b1);
    wt(DEB + 3);
    partner_u.key(1'b0);
    wt(4);
    settle();
  endtask

  initial begin
    void'($urandom(32'hF3F1E7A5));
    disp = 4'($urandom_range(15));
    wt(12);
    reset_n <= 1'b1;
    settle();
    chk("boot lamps", 32'h0, {28'h0, lamps});
    bus(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl reset", 32'h1, rd);
    bus(1'b1, OFS_CTRL, {24'h0, disp, 4'h1});
    wt(RDY);
    settle();
    chk("ready lamps", 32'h9, {28'h0, lamps});
    chk("display", {28'h0, disp}, {28'h0, display_select});
    bus(1'b1, 4'h8, 32'hFF);
    bus(1'b0, 4'hC, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl", {24'h0, disp, 4'h1}, rd);
    // Key run, then key stop with ramp
    press();
    chk("run", 32'h1, {31'h0, run_command});
    chk("run lamps", 32'h3, {28'h0, lamps});
    press();
    chk("decel", 32'h1, {31'h0, decel_stop});
    chk("decel lamps", 32'hB, {28'h0, lamps});
    wt(40);
    settle();
    chk("stopped lamps", 32'h9, {28'h0, lamps});
    // Key stop during a terminal run locks the key lamp out
    bus(1'b1, OFS_CTRL, {24'h0, disp, 4'h3});
    partner_u.term(1'b1, 1'b0);
    wt(6);
    press();
    partner_u.term(1'b0, 1'b0);
    wt(4);
    settle();
    chk("lockout", 32'h0, {31'h0, lamps.key_valid_lamp});
    wt(45);
    settle();
    chk("unlock", 32'h1, {31'h0, lamps.key_valid_lamp});
    // Trip at a random moment, cleared by the key
    wt($urandom_range(9, 1));
    trip_event <= 1'b1;
    wt(1);
    trip_event <= 1'b0;
    wt(4);
    settle();
    chk("alarm", 32'h1, {31'h0, lamps.alarm_lamp});
    press();
    chk("resets", 32'h1, resets_seen);
    chk("alarm off", 32'h0, {31'h0, lamps.alarm_lamp});
    press();
    chk("terminal src run", 32'h1, {31'h0, run_command});
    press();
    wt(40);
    // Key disabled
    bus(1'b1, OFS_CTRL, {24'h0, disp, 4'h0});
    press();
    chk("disabled", 32'h0, {31'h0, run_command});
    chk("disabled lamp", 32'h0, {31'h0, lamps.key_valid_lamp});
    // Serial selection follows the switch while the parameter is set
    bus(1'b1, OFS_CTRL, {24'h0, disp, 4'h9});
    changeover_serial <= 1'b1;
    wt(3);
    settle();
    chk("serial on", 32'h1, {31'h0, serial_proto_en});
    @(posedge core_clk);
    changeover_serial <= 1'b0;
    ext_operator_attached <= 1'b1;
    wt(3);
    settle();
    chk("serial off", 32'h0, {31'h0, serial_proto_en});
    chk("refused", 32'h1, {31'h0, ext_operator_refused});
    @(posedge core_clk);
    ext_operator_attached <= 1'b0;
    pc_param_written <= 1'b1;
    wt(1);
    pc_param_written <= 1'b0;
    power_down <= 1'b1;
    wt(4);
    settle();
    chk("commit", 32'h1, commits);
    // Key held from power-up past the hold time, then released
    @(posedge core_clk);
    power_down <= 1'b0;
    changeover_serial <= 1'b1;
    partner_u.key(1'b1);
    reset_n <= 1'b0;
    wt(12);
    reset_n <= 1'b1;
    bus(1'b1, OFS_CTRL, {24'h0, disp, 4'h9});
    wt(HLD + 5);
    partner_u.key(1'b0);
    wt(10);
    settle();
    chk("ext op", 32'h1, {31'h0, ext_operator_en});
    chk("ext op serial", 32'h0, {31'h0, serial_proto_en});
    tally_and_finish();
  end
endmodule
